// ### disk_port_pkg.sv
// package: constants and carrier types for the disk channel host port
package disk_port_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;
   // strobe timing, figures in ns at the 125 MHz clock
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETUP_NS = 70;
   localparam int STROBE_NS = 165;
   localparam int RECOVER_NS = 30;
   // least times round up
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // one request from the user side
   typedef struct packed {
      logic write;
      logic dma;
      logic ctrl_blk;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cmd_s;

   // pins that the host drives toward one channel
   typedef struct packed {
      logic cmd_sel_n;
      logic ctrl_sel_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic dma_ack_n;
      logic [ADDR_W-1:0] reg_addr;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } chan_out_s;

   // pins that one channel drives toward the host
   typedef struct packed {
      logic dma_req;
      logic drive_ready;
      logic drive_irq;
      logic [DATA_W-1:0] data_in;
   } chan_in_s;
endpackage : disk_port_pkg

// ### ide_channel_host_port.sv
// disk channel host port: two independent channels, strobes and handshake
`timescale 1ns/100ps
// Behaviour
// [RULE1] each channel drives an active-low select for the command block.
// [RULE2] each channel drives an active-low select for the control block.
// [RULE3] the drive raises dma request only in dma mode, low in pio mode.
// [RULE4] a pending dma request is granted by the active-low acknowledge.
// [RULE5] while ready is low the active strobe is held, ending after it rises; dma cycles here ignore ready.
// [RULE6] a read asserts the active-low read strobe, data sampled under it.
// [RULE7] write data is driven before the active-low write strobe falls.
// [RULE8] the drive interrupt input is sampled and forwarded as an event.
// [RULE9] drive reset out is the inverse of the active-high system reset.
// [RULE10] the activity line is only sensed by the host, never driven.
// [RULE11] the slave's diagnostic-pass line is only sensed by the host.
// [RULE12] primary cable detect is sampled and reported as status.
// [RULE13] the system reset out is active high, made from the module reset.
// [RULE14] both channels are identical independent instances of one logic.
// [RULE15] only pio and multiword dma signalling are built, no ultra mode.
module ide_channel_host_port (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [1:0] cmd_valid,
   output logic [1:0] cmd_ready,
   input disk_port_pkg::cmd_s cmd [2],
   output logic [1:0] rsp_valid,
   output logic [disk_port_pkg::DATA_W-1:0] rsp_data [2],
   output logic [1:0] dma_pending,
   output logic [1:0] irq_event,
   output disk_port_pkg::chan_out_s chan_out [2],
   input disk_port_pkg::chan_in_s chan_in [2],
   input wire logic secondary_activity_slave_present,
   input wire logic secondary_diag_passed,
   input wire logic primary_cable_detect_n,
   output logic secondary_active,
   output logic secondary_diag_ok,
   output logic cable_80_present,
   output logic system_reset_out,
   output logic drive_reset_n
);
   import disk_port_pkg::*;

   // ==========================================================
   // reset outputs
   logic rst_sync1_r;
   logic rst_sync2_r;
   // release synchronised so the drive sees a clean edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end
   assign system_reset_out = ~rst_sync2_r; // [RULE13]
   assign drive_reset_n = ~system_reset_out; // [RULE9]

   // ==========================================================
   // shared status pins, sensed only
   logic [2:0] st_s1_r;
   logic [2:0] st_s2_r;
   // two flops; open-collector lines are inputs only, never driven
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_s1_r <= 3'h0;
         st_s2_r <= 3'h0;
      end else begin
         st_s1_r <= {~primary_cable_detect_n, secondary_diag_passed,
                     secondary_activity_slave_present}; // [RULE10] [RULE11]
         st_s2_r <= st_s1_r;
      end
   end
   assign secondary_active = st_s2_r[0]; // [RULE10]
   assign secondary_diag_ok = st_s2_r[1]; // [RULE11]
   assign cable_80_present = st_s2_r[2]; // [RULE12]

   // ==========================================================
   // per-channel engines
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SETUP = 4'b0010,
      S_STROBE = 4'b0100,
      S_RECOVER = 4'b1000
   } cyc_e;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan // [RULE14]
         cyc_e state_r;
         cmd_s cur_r;
         logic [CNT_W-1:0] cnt_r;
         logic [1:0] rdy_s_r;
         logic [1:0] irq_s_r;
         logic [1:0] drq_s_r;
         logic rdy;
         logic drq;
         logic irq_d_r;
         logic rsp_v_r;
         logic [DATA_W-1:0] rsp_d_r;
         logic [DATA_W-1:0] din_s1_r;
         logic [DATA_W-1:0] din_s2_r;

         // pin sync: ready, irq, dma request and read data
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               rdy_s_r <= 2'h0;
               irq_s_r <= 2'h0;
               drq_s_r <= 2'h0;
               din_s1_r <= DATA_RST;
               din_s2_r <= DATA_RST;
            end else begin
               rdy_s_r <= {rdy_s_r[0], chan_in[ch].drive_ready};
               irq_s_r <= {irq_s_r[0], chan_in[ch].drive_irq};
               drq_s_r <= {drq_s_r[0], chan_in[ch].dma_req};
               din_s1_r <= chan_in[ch].data_in;
               din_s2_r <= din_s1_r;
            end
         end
         assign rdy = rdy_s_r[1];
         assign drq = drq_s_r[1];

         // interrupt rising edge becomes a one-cycle event
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) irq_d_r <= 1'b0;
            else irq_d_r <= irq_s_r[1];
         end
         assign irq_event[ch] = irq_s_r[1] & ~irq_d_r; // [RULE8]
         // drive only asks in dma mode, so high here means dma pending
         assign dma_pending[ch] = drq; // [RULE3]

         // cycle sequencer; ready only counts after minimum strobe
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               state_r <= S_IDLE;
               cnt_r <= '0;
               cur_r <= '0;
            end else begin
               unique case (state_r)
                  S_IDLE: begin
                     if (cmd_valid[ch] && cmd_ready[ch]) begin
                        cur_r <= cmd[ch];
                        cnt_r <= CNT_W'(SETUP_CYC);
                        state_r <= S_SETUP;
                     end
                  end
                  S_SETUP: begin
                     if (cnt_r == CNT_W'(1)) begin
                        cnt_r <= CNT_W'(STROBE_CYC);
                        state_r <= S_STROBE;
                     end else cnt_r <= cnt_r - CNT_W'(1);
                  end
                  S_STROBE: begin
                     if (cnt_r > CNT_W'(1)) cnt_r <= cnt_r - CNT_W'(1);
                     else if (cur_r.dma || rdy) begin // [RULE5]
                        cnt_r <= CNT_W'(RECOVER_CYC);
                        state_r <= S_RECOVER;
                     end
                  end
                  S_RECOVER: begin
                     if (cnt_r == CNT_W'(1)) state_r <= S_IDLE;
                     else cnt_r <= cnt_r - CNT_W'(1);
                  end
               endcase
            end
         end
         // a dma cycle only starts once the drive has asked for it
         assign cmd_ready[ch] = (state_r == S_IDLE) && rst_sync2_r
                                && (!cmd[ch].dma || drq); // [RULE4]

         // read data captured as the strobe ends
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               rsp_v_r <= 1'b0;
               rsp_d_r <= DATA_RST;
            end else begin
               rsp_v_r <= 1'b0;
               if (state_r == S_STROBE && cnt_r <= CNT_W'(1)
                   && (cur_r.dma || rdy) && !cur_r.write) begin
                  rsp_v_r <= 1'b1;
                  rsp_d_r <= din_s2_r; // [RULE6]
               end
            end
         end
         assign rsp_valid[ch] = rsp_v_r;
         assign rsp_data[ch] = rsp_d_r;

         // pin drive; no ultra redefinition of strobes or ready [RULE15]
         always_comb begin
            logic busy;
            busy = (state_r != S_IDLE);
            chan_out[ch].cmd_sel_n = ~(busy && !cur_r.dma
                                       && !cur_r.ctrl_blk); // [RULE1]
            chan_out[ch].ctrl_sel_n = ~(busy && !cur_r.dma
                                        && cur_r.ctrl_blk); // [RULE2]
            chan_out[ch].read_strobe_n = ~(state_r == S_STROBE
                                           && !cur_r.write); // [RULE6]
            chan_out[ch].write_strobe_n = ~(state_r == S_STROBE
                                            && cur_r.write); // [RULE7]
            chan_out[ch].dma_ack_n = ~(busy && cur_r.dma); // [RULE4]
            chan_out[ch].reg_addr = cur_r.addr;
            chan_out[ch].data_out = cur_r.wdata;
            chan_out[ch].data_oe = busy && cur_r.write; // [RULE7]
         end

         // ======================================================
         // checks
         property p_strobe_held;
            @(posedge clk_sys) disable iff (!arst_n)
            (state_r == S_STROBE && cnt_r <= CNT_W'(1) && !rdy
             && !cur_r.dma) |=> (state_r == S_STROBE);
         endproperty
         a_strobe_held: assert property (p_strobe_held) // [RULE5]
            else $error("strobe ended while ready low");

         property p_wdata_first;
            @(posedge clk_sys) disable iff (!arst_n)
            $fell(chan_out[ch].write_strobe_n) |->
               $past(chan_out[ch].data_oe); // [RULE7]
         endproperty
         a_wdata_first: assert property (p_wdata_first) // [RULE7]
            else $error("write strobe before data");

         property p_ack_dma;
            @(posedge clk_sys) disable iff (!arst_n)
            !chan_out[ch].dma_ack_n |-> cur_r.dma
               && chan_out[ch].cmd_sel_n && chan_out[ch].ctrl_sel_n;
         endproperty
         a_ack_dma: assert property (p_ack_dma) // [RULE4]
            else $error("ack without dma cycle");

         property p_sel_excl;
            @(posedge clk_sys) disable iff (!arst_n)
            !(chan_out[ch].cmd_sel_n == 1'b0
              && chan_out[ch].ctrl_sel_n == 1'b0);
         endproperty
         a_sel_excl: assert property (p_sel_excl) // [RULE1] [RULE2]
            else $error("both selects low");

         property p_read_strobe;
            @(posedge clk_sys) disable iff (!arst_n)
            $fell(chan_out[ch].read_strobe_n) |->
               !chan_out[ch].read_strobe_n [*2];
         endproperty
         a_read_strobe: assert property (p_read_strobe) // [RULE6]
            else $error("read strobe too short");

         property p_irq_evt;
            @(posedge clk_sys) disable iff (!arst_n)
            irq_event[ch] |=> !irq_event[ch];
         endproperty
         a_irq_evt: assert property (p_irq_evt) // [RULE8]
            else $error("irq event longer than a cycle");
      end
   endgenerate

   property p_drv_rst;
      @(posedge clk_sys) drive_reset_n == rst_sync2_r;
   endproperty
   a_drv_rst: assert property (p_drv_rst) // [RULE9]
      else $error("drive reset not inverse of system reset");

   property p_sys_rst;
      @(posedge clk_sys) disable iff (!arst_n)
      $rose(rst_sync2_r) |-> $fell(system_reset_out);
   endproperty
   a_sys_rst: assert property (p_sys_rst) // [RULE13]
      else $error("system reset out not following release");
endmodule : ide_channel_host_port

// ### disk_drive_model.sv
// behavioural disk drive standing on one host port channel
`timescale 1ns/100ps
module disk_drive_model (
   input wire logic clk_sys,
   input disk_port_pkg::chan_out_s host,
   output disk_port_pkg::chan_in_s drive,
   input wire logic dma_want,
   input wire logic irq_in,
   input wire logic [7:0] stretch
);
   import disk_port_pkg::*;
   logic [DATA_W-1:0] mem_r [16];
   logic [DATA_W-1:0] last_r = 16'h0000;
   logic [7:0] low_cnt_r = 8'h00;
   logic wr_d_r = 1'b1;
   logic stb_n;
   logic [3:0] idx;
   assign stb_n = host.read_strobe_n & host.write_strobe_n;
   assign idx = {host.ctrl_sel_n, host.reg_addr};
   // request only while the bench asks for dma mode, else low
   assign drive.dma_req = dma_want;
   assign drive.drive_irq = irq_in;
   // ready held low for stretch cycles of each strobe
   assign drive.drive_ready = stb_n | (low_cnt_r >= stretch);
   // read data only under the strobe, inverted junk after it
   assign drive.data_in = !host.read_strobe_n ? mem_r[idx] : ~last_r;
   // count strobe time, store write data as the strobe ends
   always @(posedge clk_sys) begin
      // saturate so a very long strobe never wraps back to not ready
      if (stb_n) low_cnt_r <= 8'h00;
      else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
      wr_d_r <= host.write_strobe_n;
      if (!wr_d_r && host.write_strobe_n) begin
         mem_r[idx] <= host.data_out;
      end
      if (!host.read_strobe_n) begin
         last_r <= mem_r[idx];
      end
   end
endmodule : disk_drive_model

// ### ide_channel_host_port_tb.sv
// self-checking bench for the disk channel host port
`timescale 1ns/100ps
module ide_channel_host_port_tb;
   import disk_port_pkg::*;
   logic clk_sys = 0;
   logic arst_n = 0;
   logic [1:0] cmd_valid = 0, cmd_ready, rsp_valid, dma_pending, irq_event;
   cmd_s cmd [2] = '{default: '0};
   logic [DATA_W-1:0] rsp_data [2];
   chan_out_s chan_out [2];
   chan_in_s chan_in [2];
   logic act = 0, diag = 0, cbl_n = 1, s_act, d_ok, c80, s_rst, d_rst_n;
   logic [1:0] dma_want = 0, irq = 0;
   logic [7:0] stretch [2] = '{8'h00, 8'h00};
   int num_errors = 0, tests_run = 0, cycles = 0;
   always #4 clk_sys = ~clk_sys;
   ide_channel_host_port uut (.clk_sys(clk_sys), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dma_pending(dma_pending),
      .irq_event(irq_event), .chan_out(chan_out), .chan_in(chan_in),
      .secondary_activity_slave_present(act), .secondary_diag_passed(diag),
      .primary_cable_detect_n(cbl_n), .secondary_active(s_act),
      .secondary_diag_ok(d_ok), .cable_80_present(c80),
      .system_reset_out(s_rst), .drive_reset_n(d_rst_n));
   for (genvar i = 0; i < 2; i++) begin : g_drv
      disk_drive_model m (.clk_sys(clk_sys), .host(chan_out[i]),
         .drive(chan_in[i]), .dma_want(dma_want[i]), .irq_in(irq[i]),
         .stretch(stretch[i]));
   end
   // ==========
   // checking and bus tasks
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic stb(input int c, input logic w);
      return w ? chan_out[c].write_strobe_n : chan_out[c].read_strobe_n;
   endfunction : stb
   // one transfer; selects and data judged at the first strobe cycle
   task automatic run(input int c, input logic w, d, k,
      input logic [2:0] a, input logic [15:0] wd,
      output logic [15:0] rd, output int len);
      int n;
      for (n = 0; n < 300 && cmd_ready[c] !== 1'b1; n++) @(negedge clk_sys);
      cmd[c] = '{w, d, k, a, wd};
      cmd_valid[c] = 1'b1;
      @(negedge clk_sys);
      cmd_valid[c] = 1'b0;
      for (n = 0; n < 40 && stb(c, w) !== 1'b0; n++) @(negedge clk_sys);
      chk(stb(c, w), 1'b0);
      chk(cmd_ready[c], 1'b0);
      chk(chan_out[c].reg_addr, a);
      chk(chan_out[c].dma_ack_n, !d);
      chk(chan_out[c].cmd_sel_n, d | k);
      chk(chan_out[c].ctrl_sel_n, d | !k);
      chk(chan_out[c].data_oe, w);
      if (w) chk(chan_out[c].data_out, wd);
      for (len = 0; len < 300 && stb(c, w) === 1'b0; len++)
         @(negedge clk_sys);
      for (n = 0; n < 4 && !w && rsp_valid[c] !== 1'b1; n++)
         @(negedge clk_sys);
      if (!w) chk(rsp_valid[c], 1);
      rd = rsp_data[c];
   endtask : run
   // ==========
   // scenarios
   task automatic t_reset;
      arst_n = 0;
      repeat (20) @(negedge clk_sys);
      chk({s_rst, d_rst_n, chan_out[0].read_strobe_n}, 3'b101);
      arst_n = 1;
      repeat (4) @(negedge clk_sys);
      chk({s_rst, d_rst_n}, 2'b01);
   endtask : t_reset
   task automatic t_pio;
      logic [15:0] r;
      int l;
      run(0, 1, 0, 0, 3'h5, 16'hA55A, r, l);
      chk(l >= STROBE_CYC, 1);
      run(0, 1, 0, 1, 3'h6, 16'h3C0F, r, l);
      run(0, 0, 0, 0, 3'h5, 16'h0000, r, l);
      chk(r, 16'hA55A);
      run(0, 0, 0, 1, 3'h6, 16'h0000, r, l);
      chk(r, 16'h3C0F);
   endtask : t_pio
   task automatic t_stretch;
      logic [15:0] r;
      int l;
      run(1, 1, 0, 0, 3'h2, 16'h0FF0, r, l);
      stretch[1] = 8'h28;
      run(1, 0, 0, 0, 3'h2, 16'h0000, r, l);
      chk({r, l >= 40 && l <= 48}, {16'h0FF0, 1'b1});
      stretch[1] = 8'h00;
   endtask : t_stretch
   task automatic t_both;
      logic [15:0] r0, r1;
      int l0, l1;
      fork
         run(0, 1, 0, 0, 3'h1, 16'h1111, r0, l0);
         run(1, 1, 0, 0, 3'h1, 16'h2222, r1, l1);
      join
      fork
         run(0, 0, 0, 0, 3'h1, 16'h0000, r0, l0);
         run(1, 0, 0, 0, 3'h1, 16'h0000, r1, l1);
      join
      chk({r0, r1}, {16'h1111, 16'h2222});
   endtask : t_both
   task automatic t_dma;
      logic [15:0] r;
      int l;
      dma_want[0] = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(dma_pending, 2'b01);
      stretch[0] = 8'h3C;
      run(0, 1, 1, 0, 3'h0, 16'hBEEF, r, l);
      run(0, 0, 1, 0, 3'h0, 16'h0000, r, l);
      chk({r, l < 40}, {16'hBEEF, 1'b1});
      stretch[0] = 8'h00;
      dma_want[0] = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(dma_pending, 2'b00);
   endtask : t_dma
   task automatic t_irq(input int c);
      int n;
      n = 0;
      irq[c] = 1'b1;
      repeat (8) @(negedge clk_sys) n += irq_event[c];
      irq[c] = 1'b0;
      chk(n, 1);
   endtask : t_irq
   task automatic t_sense(input logic v);
      {act, diag, cbl_n} = {v, v, !v};
      repeat (4) @(negedge clk_sys);
      chk({s_act, d_ok, c80}, {v, v, v});
   endtask : t_sense
   task automatic give_verdict;
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   // main sequence, inputs change on the falling edge
   initial begin
      @(negedge clk_sys);
      t_reset();
      t_pio();
      t_stretch();
      t_both();
      t_dma();
      t_irq(0);
      t_irq(1);
      t_sense(1'b1);
      t_sense(1'b0);
      t_reset();
      // traffic must resume cleanly after a reset in mid-run
      t_pio();
      give_verdict();
   end
endmodule : ide_channel_host_port_tb
